// ===== core/flash_array.sv
// Byte-wide flash array model with register read data and AND-only programming
module flash_array
    import flash_ctl_pkg::*;
#(
    parameter int DEPTH_W = ADDR_W
)
(
    // Clock only; the array has no reset
    input wire logic core_clk,
    // Read port
    input wire logic [DEPTH_W-1:0] rd_addr,
    output logic [7:0] rd_data,
    // Program port
    input wire logic prog_en,
    input wire logic [DEPTH_W-1:0] prog_addr,
    input wire logic [7:0] prog_data
);
    logic [7:0] mem [0:(1<<DEPTH_W)-1];

    initial
    begin
        for (int i = 0; i < (1 << DEPTH_W); i++)
        begin
            mem[i] = ERASED_BYTE;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (prog_en)
        begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== core/flash_program_controller.sv
// Program flash controller: unlock sequence, page programming, info overlay
// Functional notes
// - Info area reachable only while page-select bit 7 is set.
// - Enabled info area overlays program addresses FE00H to FFFFH.
// - Data loads see info area; instruction fetches always see main memory.
// - Info area is read-only; writes never change it.
// - Info area holds 20-char part id at FE40H-FE53H, rest reserved.
// - Two frequency bytes form one 16-bit kHz value timing program.
// - Command 00H then 5EH exposes sector protect at FF9H until the next command write.
// - Command 00H resets controller, leaves programming, relocks.
// - Write-protect option blocks all user program and erase.
// - Unlocked: program only addresses in the unlocked page, ignore others.
// - Pages inside protected sectors are never programmed.
// - Erased bytes read FFH; programming only clears bits.
// - CPU is stalled while a byte programs; clock keeps running.
// - Interrupts during programming are held until it completes.
// - Unlock: 00H, page select, then 73H then 8CH to command.
//
// Local design decision: the address-and-strobe port.
module flash_program_controller
    import flash_ctl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Program memory port from the CPU
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic mem_fetch,
    output logic [7:0] mem_rdata,
    // CPU control
    input wire logic irq_in,
    output logic cpu_stall,
    output logic irq_out,
    // Option bit
    input wire logic write_protect_opt
);
    typedef struct packed {
        lock_state_t lock;
        logic [7:0] page_sel;
        logic [7:0] sector_protect;
        logic [15:0] freq;
        logic busy;
        logic [15:0] prog_cnt;
        logic [ADDR_W-1:0] prog_addr;
        logic [7:0] prog_data;
        logic prog_fire;
        logic irq_pend;
        logic [7:0] reg_rdata;
        logic use_info;
        logic cpu_stall;
        logic irq_out;
        logic wp_s1;
        logic wp_s2;
        logic irq_s1;
        logic irq_s2;
    } state_t;

    state_t cur;
    state_t nxt;

    logic [7:0] array_rdata;
    logic [7:0] info_rdata;
    logic in_overlay;
    logic info_on;
    logic [15:0] prog_cycles;
    logic [31:0] prog_product;
    logic lock_cmd;

    // ******************************************************************
    // Overlay decode
    // ******************************************************************
    always_comb
    begin
        info_on = cur.page_sel[PAGE_SEL_INFO_BIT];
        in_overlay = mem_addr >= INFO_BASE;
    end

    flash_array #(
        .DEPTH_W(ADDR_W)
    ) u_array (
        .core_clk(core_clk),
        .rd_addr(mem_addr),
        .rd_data(array_rdata),
        .prog_en(cur.prog_fire),
        .prog_addr(cur.prog_addr),
        .prog_data(cur.prog_data)
    );

    info_area_rom u_info (
        .core_clk(core_clk),
        .rd_addr(mem_addr[PAGE_BYTE_W-1:0]),
        .rd_data(info_rdata)
    );

    // Data reads one cycle after the load; overlay applies only to data loads
    always_comb
    begin
        mem_rdata = cur.use_info ? info_rdata : array_rdata;
    end

    // ******************************************************************
    // Program time from the kHz setting
    // ******************************************************************
    always_comb
    begin
        prog_product = 32'(cur.freq) * 32'(PROG_TIME_US) / 32'(KHZ_PER_MHZ);
        // A very low setting still gives one stall cycle, so a store completes unless command 00H aborts it
        prog_cycles = (prog_product == 32'h0) ? MIN_PROG_CYCLES : prog_product[15:0];
    end

    // ******************************************************************
    // Lock command, which also aborts a byte in progress
    // ******************************************************************
    always_comb
    begin
        lock_cmd = reg_wr && reg_addr == ADDR_COMMAND && reg_wdata == CMD_LOCK;
    end

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb
    begin
        nxt = cur;
        nxt.prog_fire = 1'b0;
        // Option bit and interrupt pass two flops before any logic reads them
        nxt.wp_s1 = write_protect_opt;
        nxt.wp_s2 = cur.wp_s1;
        nxt.irq_s1 = irq_in;
        nxt.irq_s2 = cur.irq_s1;
        nxt.use_info = mem_rd && !mem_fetch && info_on && in_overlay;

        // ******************************************************************
        // Command and configuration writes
        // ******************************************************************
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_COMMAND:
                begin
                    if (reg_wdata == CMD_LOCK)
                    begin
                        nxt.lock = ST_LOCKED;
                        nxt.busy = 1'b0;
                        nxt.prog_cnt = 16'h0000;
                    end
                    else
                    begin
                        case (cur.lock)
                            ST_LOCKED:
                            begin
                                if (reg_wdata == CMD_UNLOCK_FIRST)
                                begin
                                    nxt.lock = ST_FIRST_SEEN;
                                end
                                else if (reg_wdata == CMD_PROTECT_SELECT)
                                begin
                                    nxt.lock = ST_PROTECT_SEL;
                                end
                                else
                                begin
                                    nxt.lock = ST_JAMMED;
                                end
                            end
                            ST_FIRST_SEEN:
                            begin
                                nxt.lock = (reg_wdata == CMD_UNLOCK_SECOND)
                                    ? ST_UNLOCKED : ST_JAMMED;
                            end
                            default:
                            begin
                                nxt.lock = ST_JAMMED;
                            end
                        endcase
                    end
                end
                ADDR_PAGE_SELECT:
                begin
                    nxt.page_sel = reg_wdata;
                end
                ADDR_SECTOR_PROTECT:
                begin
                    if (cur.lock == ST_PROTECT_SEL)
                    begin
                        nxt.sector_protect = reg_wdata;
                    end
                end
                ADDR_FREQ_HIGH:
                begin
                    nxt.freq[15:8] = reg_wdata;
                end
                ADDR_FREQ_LOW:
                begin
                    nxt.freq[7:0] = reg_wdata;
                end
                default:
                begin
                end
            endcase
        end

        // ******************************************************************
        // Register reads, data in the following cycle only
        // ******************************************************************
        nxt.reg_rdata = RESET_BYTE;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_COMMAND: nxt.reg_rdata = RESET_BYTE;
                ADDR_PAGE_SELECT: nxt.reg_rdata = cur.page_sel;
                ADDR_SECTOR_PROTECT:
                    nxt.reg_rdata = (cur.lock == ST_PROTECT_SEL) ? cur.sector_protect
                        : RESET_BYTE;
                ADDR_FREQ_HIGH: nxt.reg_rdata = cur.freq[15:8];
                ADDR_FREQ_LOW: nxt.reg_rdata = cur.freq[7:0];
                ADDR_STATUS:
                begin
                    nxt.reg_rdata[STAT_UNLOCKED] = (cur.lock == ST_UNLOCKED);
                    nxt.reg_rdata[STAT_PROTECT_SEL] = (cur.lock == ST_PROTECT_SEL);
                    nxt.reg_rdata[STAT_BUSY] = cur.busy;
                    nxt.reg_rdata[STAT_WRITE_PROT] = cur.wp_s2;
                end
                default: nxt.reg_rdata = RESET_BYTE;
            endcase
        end

        // ******************************************************************
        // Byte program: unlocked page, unprotected sector, no write protect
        // ******************************************************************
        if (mem_wr && !cur.busy && cur.lock == ST_UNLOCKED
            && !lock_cmd
            // A store into the overlay window is dropped, never passed to the array
            && !(info_on && in_overlay)
            && mem_addr[ADDR_W-1:PAGE_BYTE_W] == cur.page_sel[PAGE_W-1:0]
            && !cur.sector_protect[cur.page_sel[PAGE_W-1:PAGE_W-SECTOR_W]]
            && !cur.wp_s2)
        begin
            nxt.busy = 1'b1;
            nxt.prog_cnt = prog_cycles;
            nxt.prog_addr = mem_addr;
            nxt.prog_data = mem_wdata;
        end
        else if (cur.busy && !lock_cmd)
        begin
            if (cur.prog_cnt <= MIN_PROG_CYCLES)
            begin
                nxt.busy = 1'b0;
                nxt.prog_cnt = 16'h0000;
                nxt.prog_fire = 1'b1;
            end
            else
            begin
                nxt.prog_cnt = cur.prog_cnt - MIN_PROG_CYCLES;
            end
        end

        // ******************************************************************
        // Interrupts held and CPU stalled while programming
        // ******************************************************************
        nxt.irq_pend = cur.irq_s2;
        nxt.irq_out = cur.irq_pend && !nxt.busy;
        nxt.cpu_stall = nxt.busy;

        // ******************************************************************
        // Synchronous reset; array contents survive it
        // ******************************************************************
        if (!rst_n)
        begin
            nxt = '0;
            nxt.lock = ST_LOCKED;
            nxt.page_sel = RESET_BYTE;
            nxt.sector_protect = RESET_BYTE;
            nxt.freq = RESET_FREQ;
        end
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        cur <= nxt;
    end

    // ******************************************************************
    // Outputs, copied straight from state flops
    // ******************************************************************
    always_comb
    begin
        reg_rdata = cur.reg_rdata;
        cpu_stall = cur.cpu_stall;
        irq_out = cur.irq_out;
    end
endmodule

// ===== core/info_area_rom.sv
// Read-only information area holding the part identifier
module info_area_rom
    import flash_ctl_pkg::*;
#(
    parameter logic [159:0] PART_ID = 160'h4E45555452414C5F504152540000000000000000
)
(
    // Clock
    input wire logic core_clk,
    // Read port
    input wire logic [PAGE_BYTE_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // PART_ID default is arbitrary; first character sits in the top byte
    logic [7:0] next_rd_data;
    logic [PAGE_BYTE_W-1:0] idx;

    always_comb
    begin
        idx = rd_addr - PART_ID_FIRST;
        next_rd_data = RESET_BYTE;
        if (rd_addr >= PART_ID_FIRST && rd_addr <= PART_ID_LAST)
        begin
            next_rd_data = PART_ID[159 - 8*idx -: 8];
        end
    end

    always_ff @(posedge core_clk)
    begin
        rd_data <= next_rd_data;
    end
endmodule

// ===== pkg/flash_ctl_pkg.sv
// Constants, states and register map for the program flash controller
package flash_ctl_pkg;
    // Register port map (byte addresses on the plain register port)
    localparam logic [11:0] ADDR_COMMAND = 12'hFF8;
    localparam logic [11:0] ADDR_SECTOR_PROTECT = 12'hFF9;
    localparam logic [11:0] ADDR_PAGE_SELECT = 12'hFF3;
    localparam logic [11:0] ADDR_FREQ_HIGH = 12'hFFA;
    localparam logic [11:0] ADDR_FREQ_LOW = 12'hFFB;
    localparam logic [11:0] ADDR_STATUS = 12'hFF4;
    // Command codes
    localparam logic [7:0] CMD_LOCK = 8'h00;
    localparam logic [7:0] CMD_PROTECT_SELECT = 8'h5E;
    localparam logic [7:0] CMD_UNLOCK_FIRST = 8'h73;
    localparam logic [7:0] CMD_UNLOCK_SECOND = 8'h8C;
    // Memory geometry
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 7;
    localparam int PAGE_BYTE_W = 9;
    localparam int SECTOR_W = 3;
    localparam logic [15:0] INFO_BASE = 16'hFE00;
    localparam logic [8:0] PART_ID_FIRST = 9'h040;
    localparam logic [8:0] PART_ID_LAST = 9'h053;
    localparam int PAGE_SEL_INFO_BIT = 7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_FREQ = 16'h0000;
    // Program timing: about 40 us per byte, scaled by the kHz setting
    localparam int PROG_TIME_US = 40;
    localparam int KHZ_PER_MHZ = 1000;
    localparam logic [15:0] MIN_PROG_CYCLES = 16'h0001;
    // Status bit positions
    localparam int STAT_UNLOCKED = 0;
    localparam int STAT_PROTECT_SEL = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_WRITE_PROT = 3;

    typedef enum logic [2:0] {
        ST_LOCKED = 3'b000,
        ST_FIRST_SEEN = 3'b001,
        ST_UNLOCKED = 3'b010,
        ST_PROTECT_SEL = 3'b011,
        ST_JAMMED = 3'b100
    } lock_state_t;
endpackage

// ===== testbench/cpu_model.sv
// CPU-side model issuing program-memory stores and loads
module cpu_model
    import flash_ctl_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Program memory port
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_wr,
    output logic mem_rd,
    output logic mem_fetch,
    // Stall from the controller
    input wire logic cpu_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        mem_addr = 16'h0000;
        mem_wdata = 8'h00;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_fetch = 1'b0;
    end
    // Store through the program-memory path; counts the stall cycles
    task automatic store(input logic [15:0] a, input logic [7:0] d, output logic [7:0] n);
        @(posedge core_clk);
        while (cpu_stall)
            @(posedge core_clk);
        mem_addr <= a;
        mem_wdata <= d;
        mem_wr <= 1'b1;
        @(posedge core_clk);
        mem_wr <= 1'b0;
        mem_wdata <= ~d;
        n = 8'h00;
        for (int i = 0; i < 1000; i++)
        begin
            @(posedge core_clk);
            if (cpu_stall)
                n++;
            else if (n > 8'h00 || i > 1)
                break;
        end
    endtask
    task automatic load(input logic [15:0] a, input logic f);
        @(posedge core_clk);
        while (cpu_stall)
            @(posedge core_clk);
        mem_addr <= a;
        mem_rd <= 1'b1;
        mem_fetch <= f;
        @(posedge core_clk);
        mem_rd <= 1'b0;
        mem_fetch <= 1'b0;
    endtask
endmodule

// ===== testbench/flash_ctl_assertions.sv
// Port-level assertions for the program flash controller
module flash_ctl_assertions
    import flash_ctl_pkg::*;
(
    // Clock, reset and register port
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Memory port and control
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_wr,
    input wire logic cpu_stall,
    input wire logic irq_out,
    input wire logic write_protect_opt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sequence tracker: 1 locked, 3 first code, 4 unlocked, 5 protect open, 0 jammed
    logic [2:0] st;
    logic [7:0] pg;
    logic cmd;
    assign cmd = reg_wr && reg_addr == ADDR_COMMAND;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st <= 3'h1;
        else if (cmd)
            st <= reg_wdata == CMD_LOCK ? 3'h1
                : reg_wdata == CMD_PROTECT_SELECT && st == 3'h1 ? 3'h5
                : reg_wdata == CMD_UNLOCK_FIRST && st == 3'h1 ? 3'h3
                : reg_wdata == CMD_UNLOCK_SECOND && st == 3'h3 ? 3'h4 : 3'h0;
        if (!rst_n)
            pg <= 8'h00;
        else if (reg_wr && reg_addr == ADDR_PAGE_SELECT)
            pg <= reg_wdata;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_stall_cause: assert property ($rose(cpu_stall) |-> $past(mem_wr))
        else $error("stall began without a store");
    a_stall_ends: assert property ($rose(cpu_stall) |-> ##[1:1000] !cpu_stall)
        else $error("stall did not end");
    a_irq_held: assert property (cpu_stall && $past(cpu_stall) |-> !irq_out)
        else $error("interrupt passed during a store");
    a_locked_ignore: assert property (mem_wr && st != 3'h4 |=> !cpu_stall)
        else $error("store accepted while locked");
    a_page_other: assert property (
        mem_wr && st == 3'h4 && mem_addr[15:9] != pg[6:0] |=> !cpu_stall)
        else $error("store outside the unlocked page");
    a_wp_block: assert property (write_protect_opt[*3] ##0 mem_wr |=> !cpu_stall)
        else $error("store accepted under write protect");
    a_protect_hidden: assert property (
        reg_rd && reg_addr == ADDR_SECTOR_PROTECT && st != 3'h5 |=> reg_rdata == 8'h00)
        else $error("sector protect visible while closed");
    a_lock_abort: assert property (cmd && reg_wdata == CMD_LOCK |-> ##[1:2] !cpu_stall)
        else $error("stall kept after lock command");
    c_store: cover property ($rose(cpu_stall));
    c_protect: cover property (reg_rd && reg_addr == ADDR_SECTOR_PROTECT && st == 3'h5);
    c_refused: cover property (mem_wr && st == 3'h4 ##1 !cpu_stall);
endmodule

bind flash_program_controller flash_ctl_assertions u_chk (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_addr, .mem_wr, .cpu_stall, .irq_out,
    .write_protect_opt);

// ===== testbench/tb.sv
// Self-checking bench for the program flash controller
module tb
    import flash_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Same id as the info area default; the value is arbitrary
    localparam logic [159:0] PART_ID = 160'h4E45555452414C5F504152540000000000000000;
    logic core_clk, rst_n, reg_wr, reg_rd, irq_in, wp, mem_wr, mem_rd, mem_fetch;
    logic cpu_stall, irq_out;
    logic pend_r = 1'b0;
    logic pend_m = 1'b0;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, pg, d, n;
    logic [15:0] mem_addr, a, f;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int checks = 0;
    int k;

    flash_program_controller dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_fetch, .mem_rdata, .irq_in,
        .cpu_stall, .irq_out, .write_protect_opt(wp));
    cpu_model cpu (.core_clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_fetch, .cpu_stall);

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [7:0] e);
        @(posedge core_clk);
        exp_q.push_back(e);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic ld(input logic [15:0] ad, input logic fe, input logic [7:0] e);
        exp_q.push_back(e);
        cpu.load(ad, fe);
    endtask
    task automatic unlock(input logic [7:0] p);
        wr(ADDR_COMMAND, CMD_LOCK);
        wr(ADDR_PAGE_SELECT, p);
        wr(ADDR_COMMAND, CMD_UNLOCK_FIRST);
        wr(ADDR_COMMAND, CMD_UNLOCK_SECOND);
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read data is checked in the cycle after the strobe; register read data stands only then
    always @(posedge core_clk)
    begin
        if (pend_r || pend_m)
            chk(pend_m ? mem_rdata : reg_rdata, exp_q.pop_front());
        pend_r = reg_rd;
        pend_m = mem_rd;
    end
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        irq_in = 1'b0;
        wp = 1'b0;
        f = 16'h0000;
        pg = 8'h00;
        void'($urandom(76));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ADDR_SECTOR_PROTECT, 8'h00);
        wr(ADDR_COMMAND, CMD_LOCK);
        wr(ADDR_COMMAND, CMD_PROTECT_SELECT);
        rd(ADDR_STATUS, 8'h02);
        wr(ADDR_SECTOR_PROTECT, 8'h02);
        rd(ADDR_SECTOR_PROTECT, 8'h02);
        wr(ADDR_COMMAND, CMD_LOCK);
        rd(ADDR_SECTOR_PROTECT, 8'h00);
        rd(12'hFF0, 8'h00);
        // Byte programming at three kHz settings, pages in sector 0
        for (k = 1; k <= 3; k++)
        begin
            f = f + 16'h0019;
            pg = pg + 8'h03;
            // Settings of 25 to 75 kHz stay inside the supported program range
            wr(ADDR_FREQ_HIGH, f[15:8]);
            wr(ADDR_FREQ_LOW, f[7:0]);
            rd(ADDR_FREQ_HIGH, f[15:8]);
            rd(ADDR_FREQ_LOW, f[7:0]);
            a = {pg[6:0], 9'($urandom)};
            d = 8'($urandom);
            unlock(pg);
            rd(ADDR_PAGE_SELECT, pg);
            rd(ADDR_STATUS, 8'h01);
            cpu.store(a, d, n);
            chk(n, 8'(f * PROG_TIME_US / KHZ_PER_MHZ));
            cpu.store(a, 8'h0F, n);
            wr(ADDR_COMMAND, CMD_LOCK);
            ld(a, 1'b0, d & 8'h0F);
            ld(a ^ 16'h0001, 1'b0, ERASED_BYTE);
        end
        // Stores that must be ignored: other page, locked, jammed, protected, write-protect
        for (k = 0; k < 5; k++)
        begin
            pg = k == 3 ? 8'h14 : 8'h05;
            wp <= k == 4;
            unlock(pg);
            if (k == 1 || k == 2)
                wr(ADDR_COMMAND, CMD_LOCK);
            if (k == 2)
            begin
                wr(ADDR_PAGE_SELECT, pg);
                wr(ADDR_COMMAND, CMD_UNLOCK_FIRST);
                wr(ADDR_COMMAND, 8'h55);
                wr(ADDR_COMMAND, CMD_UNLOCK_SECOND);
            end
            rd(ADDR_STATUS, k == 4 ? 8'h09 : k inside {1, 2} ? 8'h00 : 8'h01);
            a = {pg[6:0], 9'h010} + (k == 0 ? 16'h0400 : 16'h0000);
            cpu.store(a, 8'h00, n);
            chk(n, 8'h00);
            ld(a, 1'b0, ERASED_BYTE);
        end
        wp <= 1'b0;
        // Info area overlay serves data loads only
        unlock(8'hFF);
        ld(INFO_BASE + 16'h0040, 1'b0, PART_ID[159:152]);
        ld(16'hFE53, 1'b0, PART_ID[7:0]);
        ld(INFO_BASE, 1'b0, 8'h00);
        ld(16'hFFFF, 1'b0, 8'h00);
        ld(16'hFE40, 1'b1, ERASED_BYTE);
        cpu.store(16'hFE40, 8'h00, n);
        chk(n, 8'h00);
        ld(16'hFE40, 1'b0, PART_ID[159:152]);
        wr(ADDR_COMMAND, CMD_LOCK);
        wr(ADDR_PAGE_SELECT, 8'h05);
        ld(16'hFE40, 1'b0, ERASED_BYTE);
        // Interrupt raised just before a store comes out after it
        unlock(8'h05);
        irq_in <= 1'b1;
        cpu.store(16'h0A20, 8'h3C, n);
        repeat (2) @(posedge core_clk);
        chk({7'h00, irq_out}, 8'h01);
        irq_in <= 1'b0;
        // Command 00H during a long store ends the stall and leaves the byte erased
        wr(ADDR_FREQ_HIGH, 8'h01);
        wr(ADDR_FREQ_LOW, 8'h00);
        unlock(8'h05);
        fork
            cpu.store(16'h0A30, 8'h00, n);
            begin
                repeat (4) @(posedge core_clk);
                wr(ADDR_COMMAND, CMD_LOCK);
            end
        join
        chk(n, 8'h04);
        ld(16'h0A30, 1'b0, ERASED_BYTE);
        results();
    end
endmodule
